// ==== core/vp_disable_control.sv ====
// Sibling virtual processor disable and enable control with AHB-Lite access
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module vp_disable_control
  import vp_disable_pkg::*;
#(
  parameter int NUM_SIB = NUM_SIB_DEFAULT
) (
  input  wire logic               MCLK,
  input  wire logic               RST_N,
  // AHB-Lite slave
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic      [31:0]        HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  // Retire stage of the issuing processor
  input  wire instr_req_t         INSTR,
  input  wire logic [3:0]         ARCH_REV,
  input  wire logic               COP0_EN,
  output retire_t                 RETIRE,
  // Memory ordering barrier toward siblings
  output logic                    SYNC_REQ,
  input  wire logic               SYNC_ACK,
  // Sibling processors
  input  wire logic [NUM_SIB-1:0] OUTSTANDING,
  input  wire logic [NUM_SIB-1:0] BG_BUSY,
  input  wire logic [NUM_SIB-1:0] EXT_FETCH_EN,
  input  wire logic [NUM_SIB-1:0] STORED_IE,
  output logic      [NUM_SIB-1:0] FETCH_EN,
  output logic      [NUM_SIB-1:0] INT_EN,
  output logic      [NUM_SIB-1:0] VP_HOLD,
  output logic      [NUM_SIB-1:0] BG_KILL
);

  typedef struct packed {
    dvp_state_t        state;
    logic              flag;
    logic              mt;
    logic [DEST_W-1:0] dest;
    retire_t           ret;
    logic              sync_req;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       hrdata;
    logic              hready;
    logic              hresp;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  logic              take;
  logic              quiet;
  logic              hold_req;
  logic              bus_sel;
  logic [31:0]       ctrl_word;

  // A request is taken only while the previous retire pulse is gone,
  // so a requester that drops valid on seeing done is never retaken.
  assign take = (st.state == ST_IDLE) && INSTR.valid && INSTR.oldest
                && !st.ret.done;
  assign quiet = (OUTSTANDING == '0) && (BG_BUSY == '0);
  // Siblings stay held from the first drain cycle until enable
  assign hold_req = st.flag || (st.state != ST_IDLE);
  assign bus_sel = HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[FLAG_BIT] = st.flag;
  end

  always_comb begin
    next_st = st;
    next_st.ret = '0;
    case (st.state)
      ST_IDLE: begin
        if (take) begin
          next_st.ret.done = 1'b1;
          if (ARCH_REV < RELEASE_MIN) begin
            next_st.ret.exc_ri = 1'b1;
          end else if (!COP0_EN) begin
            next_st.ret.exc_cpu = 1'b1;
          end else if (!INSTR.is_disable) begin
            // Gates reopen two cycles later, wait and pause states kept
            next_st.flag = 1'b0;
          end else if (!st.mt) begin
            next_st.ret.done = 1'b1;
          end else if (st.flag) begin
            // Already disabled: report it so nested pairs can back off
            next_st.ret.wr_en   = (INSTR.dest != DEST_NONE);
            next_st.ret.wr_addr = INSTR.dest;
            next_st.ret.wr_data = ctrl_word;
          end else begin
            next_st.ret.done = 1'b0;
            next_st.dest     = INSTR.dest;
            next_st.state    = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        // Retire waits for siblings to empty and background to stop
        if (quiet) begin
          next_st.sync_req = 1'b1;
          next_st.state    = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (SYNC_ACK) begin
          next_st.sync_req = 1'b0;
          next_st.state    = ST_DONE;
        end
      end
      ST_DONE: begin
        // Value returned is the one before the flag changes
        next_st.ret.done    = 1'b1;
        next_st.ret.wr_en   = (st.dest != DEST_NONE);
        next_st.ret.wr_addr = st.dest;
        next_st.ret.wr_data = ctrl_word;
        next_st.flag        = 1'b1;
        next_st.state       = ST_IDLE;
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // Zero wait states: read data is prepared during the address phase
    next_st.hready  = 1'b1;
    next_st.hresp   = HRESP_OKAY;
    next_st.wr_pend = bus_sel && HWRITE && (HSIZE == HSIZE_WORD);
    next_st.wr_addr = HADDR[ADDR_W-1:0];
    next_st.hrdata  = '0;
    if (bus_sel && !HWRITE) begin
      case (HADDR[ADDR_W-1:0])
        ADDR_VP_CTRL: begin
          next_st.hrdata = ctrl_word;
          next_st.hrdata[STATE_LSB +: $bits(dvp_state_t)] = st.state;
        end
        ADDR_CFG_FIVE: begin
          next_st.hrdata[MT_BIT] = st.mt;
        end
        default: begin
          next_st.hrdata = '0;
        end
      endcase
    end
    // Control register itself is read only; config bit steers no-op path
    if (st.wr_pend && (st.wr_addr == ADDR_CFG_FIVE)) begin
      next_st.mt = HWDATA[MT_BIT];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st          <= '0;
      st.state    <= ST_IDLE;
      st.flag     <= 1'b0;
      st.mt       <= MT_RESET;
      st.hready   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign HRDATA    = st.hrdata;
  assign HREADYOUT = st.hready;
  assign HRESP     = st.hresp;
  assign RETIRE    = st.ret;
  assign SYNC_REQ  = st.sync_req;

  // Issuer is not among the gated siblings, so its interrupts stay live
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SIB; gi++) begin : g_sib
      vp_gate u_gate (
        .clk          (MCLK),
        .rst_n        (RST_N),
        .hold_req     (hold_req),
        .ext_fetch_en (EXT_FETCH_EN[gi]),
        .stored_ie    (STORED_IE[gi]),
        .fetch_en     (FETCH_EN[gi]),
        .int_en       (INT_EN[gi]),
        .hold         (VP_HOLD[gi]),
        .bg_kill      (BG_KILL[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_drained;
    (st.state == ST_DRAIN) && quiet;
  endsequence

  sequence s_synced;
    (st.state == ST_SYNC) && SYNC_ACK;
  endsequence

  sequence s_disable_ok;
    take && INSTR.is_disable && (ARCH_REV >= RELEASE_MIN) && COP0_EN
    && st.mt && !st.flag;
  endsequence

  sequence s_enable_ok;
    take && !INSTR.is_disable && COP0_EN && (ARCH_REV >= RELEASE_MIN);
  endsequence

  a_flag_after_done: assert property (
    $rose(st.flag) |-> $past(st.state) == ST_DONE)
    else $error("disabled flag rose outside completion");

  a_drain_blocks_retire: assert property (
    (st.state == ST_DRAIN) && !quiet |=> !RETIRE.done && !st.flag)
    else $error("retired while siblings busy");

  a_full_sequence: assert property (
    s_drained ##1 s_synced |=> ##1 (RETIRE.done && st.flag))
    else $error("disable sequence did not complete in order");

  a_fetch_held: assert property (
    st.flag |=> FETCH_EN == '0)
    else $error("sibling fetch enabled while disabled");

  a_int_masked: assert property (
    st.flag |=> INT_EN == '0 && VP_HOLD == '1)
    else $error("sibling interrupts open while disabled");

  a_bg_killed: assert property (
    st.state == ST_DRAIN |=> BG_KILL == '1)
    else $error("background activity not killed in drain");

  a_nop_when_set: assert property (
    take && INSTR.is_disable && st.flag && st.mt && COP0_EN
    && (ARCH_REV >= RELEASE_MIN)
    |=> RETIRE.done && RETIRE.wr_data[FLAG_BIT] && st.state == ST_IDLE)
    else $error("repeat disable not treated as no-operation");

  a_mt_absent_nop: assert property (
    take && INSTR.is_disable && !st.mt && COP0_EN
    && (ARCH_REV >= RELEASE_MIN)
    |=> RETIRE.done && !RETIRE.wr_en && st.state == ST_IDLE)
    else $error("disable acted without multithreading");

  a_cop_unusable: assert property (
    take && !COP0_EN && (ARCH_REV >= RELEASE_MIN)
    |=> RETIRE.exc_cpu && !RETIRE.exc_ri && !RETIRE.wr_en)
    else $error("missing coprocessor unusable");

  a_reserved_instr: assert property (
    take && (ARCH_REV < RELEASE_MIN) |=> RETIRE.exc_ri && !RETIRE.wr_en)
    else $error("missing reserved instruction");

  a_dest_nonzero: assert property (
    RETIRE.wr_en |-> RETIRE.wr_addr != DEST_NONE)
    else $error("write to zero destination");

  a_prior_value: assert property (
    st.state == ST_DONE |=> RETIRE.wr_data[FLAG_BIT] == 1'b0)
    else $error("returned value not prior value");

  a_enable_clears: assert property (
    take && !INSTR.is_disable && COP0_EN && (ARCH_REV >= RELEASE_MIN)
    |=> !st.flag ##1 FETCH_EN == $past(EXT_FETCH_EN))
    else $error("enable did not release siblings");

  a_oldest_only: assert property (
    (st.state == ST_IDLE) ##1 (st.state == ST_DRAIN)
    |-> $past(INSTR.oldest))
    else $error("disable started while not oldest");

  a_disable_starts: assert property (
    s_disable_ok |=> (st.state == ST_DRAIN) && !RETIRE.done)
    else $error("disable did not enter drain");

  a_enable_done: assert property (
    s_enable_ok |=> RETIRE.done && !RETIRE.wr_en && (st.state == ST_IDLE))
    else $error("enable did not retire at once");

  a_sync_req_holds: assert property (
    SYNC_REQ && !SYNC_ACK |=> SYNC_REQ)
    else $error("barrier request dropped before acknowledge");

  a_sync_in_sync: assert property (
    SYNC_REQ |-> (st.state == ST_SYNC))
    else $error("barrier request outside barrier state");

  a_sync_after_drain: assert property (
    s_drained |=> SYNC_REQ && (st.state == ST_SYNC))
    else $error("barrier not raised after drain");

  a_done_pulse: assert property (
    RETIRE.done |=> !RETIRE.done)
    else $error("retire pulse longer than one cycle");

  a_hold_in_drain: assert property (
    (st.state == ST_DRAIN) |=> (VP_HOLD == '1) && (FETCH_EN == '0))
    else $error("siblings not held during drain");

  a_no_take_busy: assert property (
    (st.state == ST_DRAIN) || (st.state == ST_SYNC) |=> !RETIRE.done)
    else $error("retired before barrier completed");

  a_drain_exit: assert property (
    (st.state == ST_DRAIN)
    |=> (st.state == ST_DRAIN) || (st.state == ST_SYNC))
    else $error("drain left by an illegal path");

  a_dest_zero_quiet: assert property (
    (st.state == ST_DONE) && (st.dest == DEST_NONE)
    |=> !RETIRE.wr_en)
    else $error("register written for zero destination");

  a_bg_kill_flag: assert property (
    st.flag |=> (BG_KILL == '1))
    else $error("background activity live while disabled");

  a_open_when_idle: assert property (
    !st.flag && (st.state == ST_IDLE)
    |=> (FETCH_EN == $past(EXT_FETCH_EN)) && (INT_EN == $past(STORED_IE)))
    else $error("sibling gates closed while enabled");

  a_flag_fall: assert property (
    $fell(st.flag)
    |-> $past(take && !INSTR.is_disable && COP0_EN
              && (ARCH_REV >= RELEASE_MIN)))
    else $error("disabled flag cleared without enable");

  a_exc_no_effect: assert property (
    take && (!COP0_EN || (ARCH_REV < RELEASE_MIN))
    |=> $stable(st.flag) && (st.state == ST_IDLE))
    else $error("exception path changed the control state");

  a_ctrl_readback: assert property (
    bus_sel && !HWRITE && (HADDR[ADDR_W-1:0] == ADDR_VP_CTRL)
    |=> HRDATA[FLAG_BIT] == $past(st.flag))
    else $error("control readback differs from flag");

  a_cfg_readback: assert property (
    bus_sel && !HWRITE && (HADDR[ADDR_W-1:0] == ADDR_CFG_FIVE)
    |=> HRDATA[MT_BIT] == $past(st.mt))
    else $error("config readback differs from present bit");

  a_write_mt: assert property (
    st.wr_pend && (st.wr_addr == ADDR_CFG_FIVE)
    |=> st.mt == $past(HWDATA[MT_BIT]))
    else $error("config write did not land");

endmodule

// ==== core/vp_disable_pkg.sv ====
// Package of constants and carrier types for the sibling disable control
package vp_disable_pkg;

  localparam int          NUM_SIB_DEFAULT = 3;
  localparam int          ADDR_W          = 4;
  localparam int          DEST_W          = 5;
  localparam int          DATA_W          = 32;

  localparam logic [ADDR_W-1:0] ADDR_VP_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG_FIVE = 4'h4;

  localparam int          FLAG_BIT        = 0;
  localparam int          STATE_LSB       = 4;
  localparam int          MT_BIT          = 0;
  localparam logic        MT_RESET        = 1'b1;

  localparam logic [3:0]  RELEASE_MIN     = 4'h6;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
  localparam logic [2:0]  HSIZE_WORD      = 3'b010;
  localparam logic        HRESP_OKAY      = 1'b0;
  localparam logic [DEST_W-1:0] DEST_NONE = 5'h00;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_SYNC  = 4'b0100,
    ST_DONE  = 4'b1000
  } dvp_state_t;

  typedef struct packed {
    logic              valid;
    logic              is_disable;
    logic              oldest;
    logic [DEST_W-1:0] dest;
  } instr_req_t;

  typedef struct packed {
    logic              done;
    logic              exc_ri;
    logic              exc_cpu;
    logic              wr_en;
    logic [DEST_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
  } retire_t;

  typedef struct packed {
    logic fetch_en;
    logic int_en;
    logic hold;
    logic bg_kill;
  } gate_t;

endpackage

// ==== core/vp_gate.sv ====
// Per-sibling gating of fetch, interrupts and background activity
`timescale 1ns/1ps
module vp_gate
  import vp_disable_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold_req,
  input  wire logic ext_fetch_en,
  input  wire logic stored_ie,
  output logic      fetch_en,
  output logic      int_en,
  output logic      hold,
  output logic      bg_kill
);

  gate_t st;
  gate_t next_st;

  always_comb begin
    // Both controls must agree; neither can restart the other's stop
    next_st.fetch_en = ext_fetch_en && !hold_req;
    // Stored enable is only masked, never rewritten
    next_st.int_en   = stored_ie && !hold_req;
    // Wake from wait, pause or deferred exception is blocked while held
    next_st.hold     = hold_req;
    next_st.bg_kill  = hold_req;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fetch_en = st.fetch_en;
  assign int_en   = st.int_en;
  assign hold     = st.hold;
  assign bg_kill  = st.bg_kill;

endmodule

// ==== dv/sib_model.sv ====
// Behavioural model of the sibling processors sharing the core
`timescale 1ns/1ps
module sib_model #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] fetch_en,
  input  wire logic [N-1:0] bg_kill,
  input  wire logic         sync_req,
  input  wire logic [7:0]   drain_len,
  input  wire logic [7:0]   ack_len,
  output logic      [N-1:0] outstanding,
  output logic      [N-1:0] bg_busy,
  output logic              sync_ack
);
  logic [7:0] dcnt;
  logic [7:0] acnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dcnt    <= 8'h00;
      acnt    <= 8'h00;
      bg_busy <= '0;
    end else begin
      // Work in flight lingers after fetch stops
      dcnt    <= (|fetch_en) ? drain_len : dcnt - {7'h00, |dcnt};
      acnt    <= sync_req ? acnt + 8'h01 : 8'h00;
      // Walks keep running until killed, not just until fetch stops
      bg_busy <= (bg_busy | fetch_en) & ~bg_kill;
    end
  end
  assign outstanding = {N{|dcnt}};
  assign sync_ack    = sync_req && (acnt >= ack_len);
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the sibling disable control
`timescale 1ns/1ps
module tb;
  import vp_disable_pkg::*;
  localparam logic [31:0] IDLE_W = 32'h0000_0010;
  localparam logic [31:0] HELD_W = 32'h0000_0011;
  localparam logic [31:0] ZERO   = 32'h0000_0000;
  localparam logic [31:0] ONE    = 32'h0000_0001;
  logic        MCLK = 1'h0;
  logic        RST_N = 1'h0;
  logic        HSEL = 1'h0;
  logic        HWRITE = 1'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = HSIZE_WORD;
  logic [31:0] HADDR = ZERO;
  logic [31:0] HWDATA = ZERO;
  logic [31:0] HRDATA;
  logic        HREADY, HREADYOUT, HRESP, SYNC_REQ, SYNC_ACK;
  instr_req_t  INSTR = '0;
  retire_t     RETIRE;
  retire_t     rr;
  logic [3:0]  ARCH_REV = RELEASE_MIN;
  logic        COP0_EN = 1'h1;
  logic [2:0]  EXT_FETCH_EN = 3'h7;
  logic [2:0]  STORED_IE = 3'h5;
  logic [2:0]  OUTSTANDING, BG_BUSY, FETCH_EN, INT_EN, VP_HOLD, BG_KILL;
  logic [7:0]  drain_len = 8'h00;
  logic [7:0]  ack_len = 8'h00;
  logic [31:0] w;
  int          n;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  assign HREADY = HREADYOUT;
  always #2.5 MCLK = ~MCLK;

  vp_disable_control dut_u (
    .MCLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .INSTR, .ARCH_REV, .COP0_EN,
    .RETIRE, .SYNC_REQ, .SYNC_ACK, .OUTSTANDING, .BG_BUSY, .EXT_FETCH_EN,
    .STORED_IE, .FETCH_EN, .INT_EN, .VP_HOLD, .BG_KILL
  );
  sib_model sib_u (
    .clk(MCLK), .rst_n(RST_N), .fetch_en(FETCH_EN), .bg_kill(BG_KILL),
    .sync_req(SYNC_REQ), .drain_len(drain_len), .ack_len(ack_len),
    .outstanding(OUTSTANDING), .bg_busy(BG_BUSY), .sync_ack(SYNC_ACK)
  );

  task automatic complete_run;
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // Ready is looked at before the edge, so the edge's own update cannot race
  task automatic ahb(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge MCLK);
    HSEL <= 1'h1;
    HTRANS <= HTRANS_NONSEQ;
    HADDR <= a;
    HWRITE <= wr;
    do @(negedge MCLK); while (HREADY !== 1'h1);
    @(posedge MCLK);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(negedge MCLK); while (HREADY !== 1'h1);
    r = HRDATA;
    @(posedge MCLK);
  endtask

  task automatic issue(input logic dis, input logic [4:0] dst);
    @(posedge MCLK);
    INSTR <= '{valid: 1'h1, is_disable: dis, oldest: 1'h1, dest: dst};
    n = 0;
    do begin
      @(negedge MCLK);
      n++;
      chk(SYNC_REQ & (|{OUTSTANDING, BG_BUSY}), 1'h0);
    end while (RETIRE.done !== 1'h1 && n < 200);
    rr = RETIRE;
    @(posedge MCLK);
    INSTR <= '0;
  endtask

  task automatic t_regs;
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk(w, IDLE_W);
    ahb(1'h0, ADDR_CFG_FIVE, ZERO, w);
    chk(w, ONE);
    ahb(1'h1, ADDR_VP_CTRL, ONE, w);
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk(w, IDLE_W);
    ahb(1'h0, 32'h0000_0008, ZERO, w);
    chk({w, HRESP}, {ZERO, HRESP_OKAY});
    chk({FETCH_EN, INT_EN, VP_HOLD}, 9'h1e8);
  endtask

  task automatic t_disable;
    drain_len <= 8'h04;
    ack_len <= 8'h03;
    issue(1'h1, 5'h03);
    chk(rr, retire_t'{1'h1, 1'h0, 1'h0, 1'h1, 5'h03, ZERO});
    chk(n > 7, 1'h1);
    @(negedge MCLK);
    chk({FETCH_EN, INT_EN, VP_HOLD, BG_KILL}, 12'h03f);
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk(w, HELD_W);
    EXT_FETCH_EN <= 3'h0;
    @(posedge MCLK);
    EXT_FETCH_EN <= 3'h2;
    repeat (2) @(negedge MCLK);
    chk(FETCH_EN, 3'h0);
  endtask

  // Returned flag is set, so software drops this pair
  task automatic t_nested;
    issue(1'h1, 5'h05);
    chk(rr, retire_t'{1'h1, 1'h0, 1'h0, 1'h1, 5'h05, ONE});
    chk(n[7:0], 8'h02);
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk(w, HELD_W);
  endtask

  task automatic t_enable;
    issue(1'h0, 5'h07);
    chk({rr[40:37], n[7:0]}, 12'h802);
    @(negedge MCLK);
    chk({FETCH_EN, INT_EN, VP_HOLD, BG_KILL}, 12'h540);
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk(w, IDLE_W);
    EXT_FETCH_EN <= 3'h7;
  endtask

  task automatic t_dest0;
    drain_len <= 8'h00;
    ack_len <= 8'h00;
    issue(1'h1, DEST_NONE);
    chk(rr, retire_t'{1'h1, 1'h0, 1'h0, 1'h0, DEST_NONE, ZERO});
    issue(1'h0, DEST_NONE);
    chk(rr[40:37], 4'h8);
  endtask

  task automatic t_exc;
    ARCH_REV <= 4'h5;
    issue(1'h1, 5'h03);
    chk(rr[40:37], 4'hc);
    ARCH_REV <= RELEASE_MIN;
    COP0_EN <= 1'h0;
    issue(1'h1, 5'h03);
    chk(rr[40:37], 4'ha);
    COP0_EN <= 1'h1;
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk({w, FETCH_EN}, {IDLE_W, 3'h7});
  endtask

  task automatic t_no_mt;
    ahb(1'h1, ADDR_CFG_FIVE, ZERO, w);
    issue(1'h1, 5'h03);
    chk({rr[40:37], n[7:0]}, 12'h802);
    ahb(1'h0, ADDR_VP_CTRL, ZERO, w);
    chk(w, IDLE_W);
    ahb(1'h1, ADDR_CFG_FIVE, ONE, w);
    ahb(1'h0, ADDR_CFG_FIVE, ZERO, w);
    chk(w, ONE);
  endtask

  task automatic t_oldest;
    @(posedge MCLK);
    INSTR <= '{valid: 1'h1, is_disable: 1'h1, oldest: 1'h0, dest: 5'h03};
    repeat (8) begin
      @(negedge MCLK);
      chk({RETIRE.done, FETCH_EN}, 4'h7);
    end
    @(posedge MCLK);
    INSTR <= '0;
  endtask

  initial begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'h1;
    t_regs;
    t_disable;
    t_nested;
    t_enable;
    t_dest0;
    t_exc;
    t_no_mt;
    t_oldest;
    complete_run;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      complete_run;
    end
  end
endmodule
